/* hw/sfhw_pkg.sv */
// shared constants and types of the serial flash hold / write-protect pair
// assumes both ends run on one 20 MHz ref_clk and meet through sfhw_if
package sfhw_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] write_enable_cmd = 8'h06;
  localparam logic [7:0] write_disable_cmd = 8'h04;
  localparam logic [7:0] status_read_cmd = 8'h05;
  localparam logic [7:0] status_write_cmd = 8'h01;
  localparam logic [7:0] page_program_cmd = 8'h02;
  localparam logic [7:0] sector_erase_cmd = 8'h20;
  localparam logic [7:0] sector_erase_alt_cmd = 8'hd7;
  localparam logic [7:0] block_erase_cmd = 8'hd8;
  localparam logic [7:0] chip_erase_cmd = 8'h60;
  localparam logic [7:0] chip_erase_alt_cmd = 8'hc7;

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int busy_bit = 0;
  localparam int wel_bit = 1;
  localparam int size0_bit = 2;
  localparam int size2_bit = 4;
  localparam int top_bottom_bit = 5;
  localparam int reserved_bit = 6;
  localparam int lock_bit = 7;
  // non-volatile image {lock, top_bottom, size2, size1, size0}
  localparam logic [4:0] nv_init = 5'h00;

  // ----------------------------------------------------------------
  // array geometry and frame lengths in bytes
  // ----------------------------------------------------------------
  localparam int blk_msb = 19;
  localparam int blk_lsb = 16;
  localparam logic [4:0] array_blocks = 5'h10;
  localparam logic [2:0] len_one = 3'h1;
  localparam logic [2:0] len_status_write = 3'h2;
  localparam logic [2:0] len_erase = 3'h4;
  localparam logic [2:0] len_program = 3'h5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned busy_default = 64;
  localparam logic [3:0] sck_half = 4'h8;
  // cs_n, sck, mosi, hold_n, wp_n levels while idle
  localparam logic [4:0] pin_idle = 5'h13;

  // ----------------------------------------------------------------
  // host register map and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] reg_ctrl = 3'h0;
  localparam logic [2:0] reg_tx = 3'h1;
  localparam logic [2:0] reg_rx = 3'h2;
  localparam logic [2:0] reg_stat = 3'h3;
  localparam logic [2:0] reg_pins = 3'h4;
  localparam int ctrl_go = 0;
  localparam int ctrl_last = 1;
  localparam int ctrl_drop = 2;
  localparam int pins_pause = 0;
  localparam int pins_wp_n = 1;
  localparam int stat_run = 0;
  localparam int stat_sel = 1;
  localparam int stat_paused = 2;
  localparam int stat_refused = 3;
  localparam int stat_busy_seen = 4;
  localparam int stat_armed = 5;

  typedef enum logic [1:0] {op_program, op_sector, op_block, op_chip} sfhw_op_t;
  typedef enum logic [1:0] {eng_idle, eng_low, eng_high} sfhw_eng_t;

endpackage

/* hw/sfhw_if.sv */
// pin bundle between flash device and its host controller
// assumes so_level models a pulled-up data-out line
`timescale 1ns/1ps
`default_nettype none
interface sfhw_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic hold_n;
  logic wp_n;
  logic so_level;

  // released line reads high
  assign so_level = miso_oe ? miso : 1'b1;

  modport device (input cs_n, sck, mosi, hold_n, wp_n, output miso, miso_oe);
  modport host (output cs_n, sck, mosi, hold_n, wp_n, input so_level);
endinterface
`default_nettype wire

/* hw/sfhw_device.sv */
// flash device end: pause input, write protect, status register
// assumes pins are asynchronous to ref_clk and sck half period >= 4 cycles
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sfhw_device #(
  parameter int unsigned busy_cycles = sfhw_pkg::busy_default
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // flash pins
  sfhw_if.device pins,
  // array side
  output logic op_strobe,
  output sfhw_pkg::sfhw_op_t op_kind,
  output logic [23:0] op_addr,
  output logic [7:0] status_view
);

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  function automatic logic block_protected(input logic [3:0] blk, input logic [2:0] size,
                                           input logic bottom);
    logic [4:0] n;
    n = (size == 3'h0) ? 5'h00 :
        (size > 3'h4) ? sfhw_pkg::array_blocks : 5'(5'h01 << (size - 3'h1));
    if (bottom)
      block_protected = {1'b0, blk} < n;
    else
      block_protected = {1'b0, blk} >= 5'(sfhw_pkg::array_blocks - n);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] pin_prev;
  wire [4:0] pin_raw = {pins.cs_n, pins.sck, pins.mosi, pins.hold_n, pins.wp_n};

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      sync_a <= sfhw_pkg::pin_idle;
      sync_b <= sfhw_pkg::pin_idle;
      pin_prev <= sfhw_pkg::pin_idle;
    end
    else
    begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
      pin_prev <= sync_b;
    end
  end

  wire cs_s = sync_b[4];
  wire sck_s = sync_b[3];
  wire mosi_s = sync_b[2];
  wire hold_s = sync_b[1];
  wire wp_s = sync_b[0];
  wire sck_rise = sck_s & ~pin_prev[3];
  wire sck_fall = ~sck_s & pin_prev[3];
  wire cs_rise = cs_s & ~pin_prev[4];
  // hold edges taken only while sck low; an edge with sck high is ignored
  wire hold_fall = ~hold_s & pin_prev[1] & ~sck_s;
  wire hold_rise = hold_s & ~pin_prev[1] & ~sck_s;

  // ----------------------------------------------------------------
  // pause state
  // ----------------------------------------------------------------
  logic paused;
  wire next_paused = cs_s ? 1'b0 : (hold_fall ? 1'b1 : (hold_rise ? 1'b0 : paused));
  // counters are frozen while paused, so the frame resumes on the same bit
  wire active = ~cs_s & ~paused;
  wire rise_ok = sck_rise & active;
  wire fall_ok = sck_fall & active;

  // ----------------------------------------------------------------
  // input shifter
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  logic [6:0] in_sr;
  logic [7:0] cmd;
  logic [23:0] addr;
  logic [7:0] wsr_byte;
  wire [7:0] in_byte = {in_sr, mosi_s};
  wire byte_done = rise_ok & (bit_cnt == 3'h7);

  always_ff @(posedge ref_clk)
  begin
    if (reset || cs_s)
    begin
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      in_sr <= 7'h00;
    end
    else if (rise_ok)
    begin
      in_sr <= in_byte[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_done && byte_cnt != sfhw_pkg::len_program)
        byte_cnt <= byte_cnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      cmd <= 8'h00;
      addr <= 24'h000000;
      wsr_byte <= 8'h00;
    end
    else if (byte_done)
    begin
      if (byte_cnt == 3'h0)
        cmd <= in_byte;
      if (byte_cnt != 3'h0 && byte_cnt < sfhw_pkg::len_erase)
        addr <= {addr[15:0], in_byte};
      if (byte_cnt == sfhw_pkg::len_one)
        wsr_byte <= in_byte;
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  logic busy;
  logic write_enable_latch;
  logic [15:0] busy_cnt;
  // no reset: these model cells that keep their value over power cycles
  logic [4:0] nv_bits = sfhw_pkg::nv_init;
  wire protect_lock = nv_bits[4];
  wire protect_top_bottom = nv_bits[3];
  wire [2:0] protect_size = nv_bits[2:0];
  logic [7:0] status_byte;

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[sfhw_pkg::busy_bit] = busy;
    status_byte[sfhw_pkg::wel_bit] = write_enable_latch;
    status_byte[sfhw_pkg::size2_bit:sfhw_pkg::size0_bit] = protect_size;
    status_byte[sfhw_pkg::top_bottom_bit] = protect_top_bottom;
    status_byte[sfhw_pkg::lock_bit] = protect_lock;
  end

  // ----------------------------------------------------------------
  // command execution at deselect
  // ----------------------------------------------------------------
  // a deselect while paused abandons the frame
  wire exec = cs_rise & ~paused & (bit_cnt == 3'h0) & ~busy;
  wire is_write_enable_cmd = (cmd == sfhw_pkg::write_enable_cmd) & (byte_cnt == sfhw_pkg::len_one);
  wire is_write_disable_cmd = (cmd == sfhw_pkg::write_disable_cmd) & (byte_cnt == sfhw_pkg::len_one);
  wire is_wsr = (cmd == sfhw_pkg::status_write_cmd) & (byte_cnt == sfhw_pkg::len_status_write);
  wire is_prog = (cmd == sfhw_pkg::page_program_cmd) & (byte_cnt == sfhw_pkg::len_program);
  wire is_sect = ((cmd == sfhw_pkg::sector_erase_cmd) | (cmd == sfhw_pkg::sector_erase_alt_cmd))
                 & (byte_cnt == sfhw_pkg::len_erase);
  wire is_blk = (cmd == sfhw_pkg::block_erase_cmd) & (byte_cnt == sfhw_pkg::len_erase);
  wire is_chip = ((cmd == sfhw_pkg::chip_erase_cmd) | (cmd == sfhw_pkg::chip_erase_alt_cmd))
                 & (byte_cnt == sfhw_pkg::len_one);
  wire addr_prot = block_protected(addr[sfhw_pkg::blk_msb:sfhw_pkg::blk_lsb], protect_size,
                                   protect_top_bottom);
  wire unlocked = wp_s | ~protect_lock;
  wire go_wsr = exec & is_wsr & write_enable_latch & unlocked;
  wire go_arr = exec & write_enable_latch
                & (((is_prog | is_sect | is_blk) & ~addr_prot)
                   | (is_chip & (protect_size == 3'h0)));
  wire go_write_enable_cmd = exec & is_write_enable_cmd;
  wire go_write_disable_cmd = exec & is_write_disable_cmd;
  wire [1:0] kind_sel = is_prog ? 2'(sfhw_pkg::op_program) :
                        is_sect ? 2'(sfhw_pkg::op_sector) :
                        is_blk ? 2'(sfhw_pkg::op_block) : 2'(sfhw_pkg::op_chip);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      write_enable_latch <= 1'b0;
    else if (go_write_enable_cmd)
      write_enable_latch <= 1'b1;
    else if (go_write_disable_cmd || go_wsr || go_arr)
      write_enable_latch <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      busy <= 1'b0;
      busy_cnt <= 16'h0000;
    end
    else if (go_arr)
    begin
      busy <= 1'b1;
      busy_cnt <= 16'(busy_cycles - 1);
    end
    else if (busy_cnt != 16'h0000)
      busy_cnt <= busy_cnt - 16'h0001;
    else
      busy <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (go_wsr)
      nv_bits <= {wsr_byte[sfhw_pkg::lock_bit],
                  wsr_byte[sfhw_pkg::top_bottom_bit:sfhw_pkg::size0_bit]};
  end

  // ----------------------------------------------------------------
  // status read output
  // ----------------------------------------------------------------
  logic out_on;
  logic out_drv;
  logic [7:0] out_sr;
  logic [2:0] out_cnt;
  wire start_read = byte_done & (byte_cnt == 3'h0) & (in_byte == sfhw_pkg::status_read_cmd);
  wire next_oe = out_drv & ~cs_s & ~next_paused;

  always_ff @(posedge ref_clk)
  begin
    if (reset || cs_s)
    begin
      out_on <= 1'b0;
      out_drv <= 1'b0;
      out_sr <= 8'h00;
      out_cnt <= 3'h0;
    end
    else if (start_read)
    begin
      out_on <= 1'b1;
      out_sr <= status_byte;
      out_cnt <= 3'h0;
    end
    else if (fall_ok && out_on)
    begin
      out_drv <= 1'b1;
      out_cnt <= out_cnt + 3'h1;
      // reload a fresh snapshot each byte so polling sees busy drop
      out_sr <= (out_cnt == 3'h7) ? status_byte : {out_sr[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pins.miso <= 1'b0;
      pins.miso_oe <= 1'b0;
      paused <= 1'b0;
      op_strobe <= 1'b0;
      op_kind <= sfhw_pkg::op_program;
      op_addr <= 24'h000000;
      status_view <= 8'h00;
    end
    else
    begin
      if (fall_ok && out_on)
        pins.miso <= out_sr[7];
      pins.miso_oe <= next_oe;
      paused <= next_paused;
      op_strobe <= go_arr;
      if (go_arr)
      begin
        op_kind <= sfhw_pkg::sfhw_op_t'(kind_sel);
        op_addr <= addr;
      end
      status_view <= status_byte;
    end
  end

endmodule
`default_nettype wire

/* hw/sfhw_host.sv */
// host end: byte engine driving flash pins, pause and protect control
// assumes software uses the plain register port; sck made by a divider
`timescale 1ns/1ps
`default_nettype none
module sfhw_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // flash pins
  sfhw_if.host pins,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);

  function automatic logic is_write_class(input logic [7:0] c);
    is_write_class = (c == sfhw_pkg::page_program_cmd) || (c == sfhw_pkg::sector_erase_cmd)
                     || (c == sfhw_pkg::sector_erase_alt_cmd) || (c == sfhw_pkg::block_erase_cmd)
                     || (c == sfhw_pkg::chip_erase_cmd) || (c == sfhw_pkg::chip_erase_alt_cmd)
                     || (c == sfhw_pkg::status_write_cmd);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfhw_pkg::sfhw_eng_t state;
  logic [3:0] cnt;
  logic [2:0] bit_idx;
  logic [7:0] tx_data;
  logic [7:0] tx_sr;
  logic [7:0] rx_sr;
  logic [7:0] rx_data;
  logic last_req;
  logic pause_req;
  logic wp_req;
  logic refused;
  logic busy_seen;
  logic armed;
  logic past_first;
  logic [7:0] frame_cmd;
  logic miso_a;
  logic miso_b;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire ctrl_wr = wr & (addr == sfhw_pkg::reg_ctrl);
  wire go_req = ctrl_wr & wdata[sfhw_pkg::ctrl_go];
  wire drop_req = ctrl_wr & wdata[sfhw_pkg::ctrl_drop];
  wire first = pins.cs_n;
  wire blocked = first & ((busy_seen & (tx_data != sfhw_pkg::status_read_cmd))
                          | (is_write_class(tx_data) & ~armed));
  wire start = go_req & (state == sfhw_pkg::eng_idle) & ~blocked & ~drop_req;
  wire half_end = cnt == 4'(sfhw_pkg::sck_half - 4'h1);
  // hold may only move with sck low and chip selected
  wire hold_slot = (state == sfhw_pkg::eng_idle) | ((state == sfhw_pkg::eng_low) & (cnt == 4'h0));
  wire next_hold_n = (drop_req | pins.cs_n) ? 1'b1 : (hold_slot ? ~pause_req : pins.hold_n);
  wire stall = (state == sfhw_pkg::eng_low) & (cnt == 4'h0) & ~next_hold_n;
  wire [7:0] rx_next = {rx_sr[6:0], miso_b};
  wire byte_end = (state == sfhw_pkg::eng_high) & half_end & (bit_idx == 3'h7);
  logic [7:0] read_mux;

  always_comb
  begin
    read_mux = 8'h00;
    if (addr == sfhw_pkg::reg_tx)
      read_mux = tx_data;
    else if (addr == sfhw_pkg::reg_rx)
      read_mux = rx_data;
    else if (addr == sfhw_pkg::reg_pins)
    begin
      read_mux[sfhw_pkg::pins_pause] = pause_req;
      read_mux[sfhw_pkg::pins_wp_n] = wp_req;
    end
    else if (addr == sfhw_pkg::reg_stat)
    begin
      read_mux[sfhw_pkg::stat_run] = state != sfhw_pkg::eng_idle;
      read_mux[sfhw_pkg::stat_sel] = ~pins.cs_n;
      read_mux[sfhw_pkg::stat_paused] = ~pins.hold_n;
      read_mux[sfhw_pkg::stat_refused] = refused;
      read_mux[sfhw_pkg::stat_busy_seen] = busy_seen;
      read_mux[sfhw_pkg::stat_armed] = armed;
    end
  end

  // ----------------------------------------------------------------
  // registers and miso synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_data <= 8'h00;
      pause_req <= 1'b0;
      wp_req <= 1'b1;
      refused <= 1'b0;
      rdata <= 8'h00;
      miso_a <= 1'b1;
      miso_b <= 1'b1;
    end
    else
    begin
      if (wr && addr == sfhw_pkg::reg_tx)
        tx_data <= wdata;
      if (wr && addr == sfhw_pkg::reg_pins)
      begin
        pause_req <= wdata[sfhw_pkg::pins_pause];
        wp_req <= wdata[sfhw_pkg::pins_wp_n];
      end
      if (go_req && blocked)
        refused <= 1'b1;
      else if (start)
        refused <= 1'b0;
      rdata <= rd ? read_mux : 8'h00;
      miso_a <= pins.so_level;
      miso_b <= miso_a;
    end
  end

  // ----------------------------------------------------------------
  // frame guard
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      armed <= 1'b0;
      busy_seen <= 1'b0;
      frame_cmd <= 8'h00;
      past_first <= 1'b0;
    end
    else
    begin
      if (start && first)
      begin
        frame_cmd <= tx_data;
        if (tx_data == sfhw_pkg::write_enable_cmd)
          armed <= 1'b1;
        else if (is_write_class(tx_data) || tx_data == sfhw_pkg::write_disable_cmd)
          armed <= 1'b0;
      end
      if (pins.cs_n)
        past_first <= 1'b0;
      else if (byte_end)
      begin
        past_first <= 1'b1;
        if (past_first && frame_cmd == sfhw_pkg::status_read_cmd)
          busy_seen <= rx_next[sfhw_pkg::busy_bit];
      end
    end
  end

  // ----------------------------------------------------------------
  // byte engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset || drop_req)
    begin
      state <= sfhw_pkg::eng_idle;
      cnt <= 4'h0;
      bit_idx <= 3'h0;
      tx_sr <= 8'h00;
      pins.cs_n <= 1'b1;
      pins.sck <= 1'b0;
      pins.mosi <= 1'b0;
      last_req <= 1'b0;
    end
    else
    begin
      unique case (state)
        sfhw_pkg::eng_idle:
        begin
          if (start)
          begin
            pins.cs_n <= 1'b0;
            tx_sr <= tx_data;
            pins.mosi <= tx_data[7];
            bit_idx <= 3'h0;
            cnt <= 4'h0;
            last_req <= wdata[sfhw_pkg::ctrl_last];
            state <= sfhw_pkg::eng_low;
          end
        end
        sfhw_pkg::eng_low:
        begin
          if (half_end)
          begin
            pins.sck <= 1'b1;
            cnt <= 4'h0;
            state <= sfhw_pkg::eng_high;
          end
          else if (!stall)
            cnt <= cnt + 4'h1;
        end
        sfhw_pkg::eng_high:
        begin
          if (half_end)
          begin
            pins.sck <= 1'b0;
            cnt <= 4'h0;
            if (bit_idx == 3'h7)
            begin
              state <= sfhw_pkg::eng_idle;
              if (last_req)
                pins.cs_n <= 1'b1;
            end
            else
            begin
              bit_idx <= bit_idx + 3'h1;
              tx_sr <= {tx_sr[6:0], 1'b0};
              pins.mosi <= tx_sr[6];
              state <= sfhw_pkg::eng_low;
            end
          end
          else
            cnt <= cnt + 4'h1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_sr <= 8'h00;
      rx_data <= 8'h00;
      pins.hold_n <= 1'b1;
      pins.wp_n <= 1'b1;
    end
    else
    begin
      if (state == sfhw_pkg::eng_high && half_end)
        rx_sr <= rx_next;
      if (byte_end)
        rx_data <= rx_next;
      pins.hold_n <= next_hold_n;
      pins.wp_n <= wp_req;
    end
  end

endmodule
`default_nettype wire

/* verif/sfhw_properties.sv */
// pin checks on the flash link
// assumes one ref_clk domain; tb wires it beside the link
`timescale 1ns/1ps
`default_nettype none
module sfhw_properties (
  // clock, reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic hold_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  AST_PAUSE_SEL: assert property ($fell(hold_n) |-> !cs_n)
    else $error("pause unselected");
  AST_PAUSE_SCK: assert property ($changed(hold_n) |-> !sck)
    else $error("pause moved, clock high");
  AST_PAUSE_OFF: assert property ($fell(hold_n) && !sck |-> ##[1:8] !miso_oe)
    else $error("output kept on pause");
  AST_PAUSE_QUIET: assert property (!hold_n [*8] |-> !miso_oe)
    else $error("output on while paused");
  AST_PAUSE_FROZEN: assert property (!hold_n && !$past(hold_n)
    |-> $stable(sck) && $stable(mosi)) else $error("clock moved while paused");
  AST_DESEL_OFF: assert property ($rose(cs_n) |-> ##[1:8] !miso_oe)
    else $error("output kept after deselect");
  AST_OUT_SEL: assert property ($rose(miso_oe) |-> !cs_n && hold_n)
    else $error("output on unselected");
  AST_OUT_KEEP: assert property ($fell(miso_oe) |-> cs_n || !hold_n)
    else $error("status stream cut");
endmodule
`default_nettype wire

/* verif/tb.sv */
// bench: host and device joined by the link, driven through registers
// assumes 20 MHz ref_clk; busy count shortened to 8
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic wp = 1'b1;
  logic saw_busy = 1'b0;
  logic [7:0] rdata;
  logic op_strobe;
  sfhw_pkg::sfhw_op_t op_kind;
  logic [23:0] op_addr;
  logic [7:0] status_view;
  logic [7:0] st;
  logic [7:0] v;
  logic [3:0] rnd_blk;
  int n_mismatch = 0;
  int checks = 0;
  int n_ops = 0;
  sfhw_if link();
  sfhw_host sfhw_host_i (.ref_clk(ref_clk), .reset(reset), .pins(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  sfhw_device #(.busy_cycles(8)) sfhw_device_i (.ref_clk(ref_clk), .reset(reset),
    .pins(link), .op_strobe(op_strobe), .op_kind(op_kind), .op_addr(op_addr),
    .status_view(status_view));
  sfhw_properties sfhw_properties_i (.ref_clk(ref_clk), .reset(reset), .cs_n(link.cs_n),
    .sck(link.sck), .mosi(link.mosi), .miso_oe(link.miso_oe), .hold_n(link.hold_n));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    if (op_strobe === 1'b1)
      n_ops <= n_ops + 1;
    if (status_view[0] === 1'b1)
      saw_busy <= 1'b1;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // program acceptance expected from the size and placement table
  function automatic logic prog_ok(input logic [7:0] s, input logic [3:0] blk);
    int n;
    case (s[4:2])
      3'h0: n = 0;
      3'h1: n = 1;
      3'h2: n = 2;
      3'h3: n = 4;
      3'h4: n = 8;
      default: n = 16;
    endcase
    prog_ok = s[5] ? (int'(blk) >= n) : (int'(blk) < 16 - n);
  endfunction
  // a gap cycle after each strobe keeps one assignment per time step
  task automatic wreg(input logic [2:0] ad, input logic [7:0] d);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rreg(input logic [2:0] ad);
    addr <= ad;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 st = rdata;
    @(posedge ref_clk);
  endtask
  // p: 0 plain, 1 pause then resume, 2 pause then abort
  task automatic xfer(input logic [7:0] b, input logic last, input int p);
    wreg(3'h1, b);
    wreg(3'h0, {6'h00, last, 1'b1});
    if (p != 0)
    begin
      // abort waits out the byte, so only the pause can stop the command
      repeat ((p == 2) ? 140 : $urandom_range(40, 5)) @(posedge ref_clk);
      wreg(3'h4, {6'h00, wp, 1'b1});
      repeat (60) @(posedge ref_clk);
      rreg(3'h3);
      cmp(24'(st[2]), 24'h1);
      cmp(24'(link.miso_oe), 24'h0);
      wreg(3'h0, (p == 2) ? 8'h04 : 8'h00);
      wreg(3'h4, {6'h00, wp, 1'b0});
    end
    repeat (300)
    begin
      rreg(3'h3);
      if (st[0] !== 1'b1)
        break;
    end
    cmp(24'(st[0]), 24'h0);
  endtask
  task automatic frame(input logic [39:0] b, input int n);
    for (int k = 0; k < n; k++)
      xfer(b[39 - 8 * k -: 8], k == n - 1, 0);
    repeat (20) @(posedge ref_clk);
  endtask
  task automatic wsr(input logic [7:0] d);
    frame(40'h0600000000, 1);
    frame({8'h01, d, 24'h000000}, 2);
  endtask
  task automatic rdstat(input logic [7:0] e, input int p);
    xfer(8'h05, 1'b0, 0);
    xfer(8'h00, 1'b0, 0);
    rreg(3'h2);
    cmp(24'(st), 24'(e));
    xfer(8'h00, 1'b1, p);
    rreg(3'h2);
    cmp(24'(st), 24'(e));
  endtask
  task automatic op(input logic [7:0] c, input logic [3:0] blk, input int n, input logic ok);
    int n0;
    logic [23:0] a;
    n0 = n_ops;
    a = {4'h0, blk, 16'($urandom)};
    frame(40'h0600000000, 1);
    frame({c, a, 8'($urandom)}, n);
    cmp(24'(n_ops - n0), 24'(ok));
    if (ok && n > 1)
      cmp(op_addr, a);
  endtask
  initial
  begin
    void'($urandom(44419));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rdstat(8'h00, 0);
    frame(40'h0600000000, 1);
    cmp(24'(status_view), 24'h02);
    frame(40'h0400000000, 1);
    cmp(24'(status_view), 24'h00);
    v = 8'($urandom) | 8'h80;
    wsr(v);
    cmp(24'(status_view), 24'(v & 8'hbc));
    rdstat(v & 8'hbc, 1);
    wp = 1'b0;
    wreg(3'h4, 8'h00);
    wsr(8'h04);
    cmp(24'(status_view), 24'(v & 8'hbc | 8'h02));
    wp = 1'b1;
    wreg(3'h4, 8'h02);
    wsr(8'h04);
    cmp(24'(status_view), 24'h04);
    op(8'h02, 4'hf, 5, 1'b0);
    op(8'h02, 4'($urandom_range(14, 0)), 5, 1'b1);
    cmp(24'(saw_busy), 24'h1);
    cmp(24'(status_view), 24'h04);
    for (int k = 0; k < 3; k++)
    begin
      op(k == 0 ? 8'h20 : k == 1 ? 8'hd7 : 8'hd8, 4'h3, 4, 1'b1);
      cmp(24'(op_kind), k < 2 ? 24'h1 : 24'h2);
    end
    op(8'hc7, 4'h0, 1, 1'b0);
    wsr(8'h24);
    op(8'h02, 4'h0, 5, 1'b0);
    op(8'h02, 4'hf, 5, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      v = 8'($urandom) & 8'h3c;
      rnd_blk = 4'($urandom);
      wsr(v);
      op(8'h02, rnd_blk, 5, prog_ok(v, rnd_blk));
    end
    wsr(8'h00);
    op(8'h60, 4'h0, 1, 1'b1);
    cmp(24'(op_kind), 24'(sfhw_pkg::op_chip));
    xfer(8'h02, 1'b1, 0);
    rreg(3'h3);
    cmp(24'(st[5:3]), 24'h1);
    xfer(8'h06, 1'b0, 2);
    repeat (20) @(posedge ref_clk);
    cmp(24'(status_view), 24'h00);
    tally_and_finish();
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
